// file: rtl/cic_pkg.sv
// Shared constants and register map of the input conditioning block
package cic_pkg;

  // Clock and timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int DEAD_MAX_MS = 250;
  localparam int SHOT_US     = 250;
  localparam int MS_CYC      = CLK_HZ / 1000;
  localparam int SHOT_CYC    = SHOT_US * (CLK_HZ / 1_000_000);

  // Counter widths sized for the default counts
  localparam int SUBW  = 15;
  localparam int SHOTW = 13;

  // Line counts
  localparam int NDIR  = 10;
  localparam int NVIRT = 4;
  localparam int NPLS  = 4;

  // Register bus
  localparam int ADDRW = 8;
  localparam int DATAW = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] DFUNC_BASE = 8'h00;
  localparam logic [7:0] DCOMP_BASE = 8'h28;
  localparam logic [7:0] DINV_OFF   = 8'h50;
  localparam logic [7:0] DDEAD_OFF  = 8'h54;
  localparam logic [7:0] DSHOT_OFF  = 8'h58;
  localparam logic [7:0] VFUNC_BASE = 8'h60;
  localparam logic [7:0] VSRC_BASE  = 8'h70;
  localparam logic [7:0] VINV_OFF   = 8'h80;
  localparam logic [7:0] VDEAD_OFF  = 8'h84;
  localparam logic [7:0] VSHOT_OFF  = 8'h88;
  localparam logic [7:0] STAT_OFF   = 8'h8c;

  // Status field positions
  localparam int STAT_DIR_LSB  = 0;
  localparam int STAT_VIRT_LSB = 10;
  localparam int STAT_PLS_BIT  = 16;

  // Function codes and the dead-time limit
  localparam logic [7:0] CODE_NOT_USED  = 8'h00;
  localparam logic [7:0] CODE_CONST_OFF = 8'h80;
  localparam logic [7:0] DEAD_MAX       = 8'hfa;

  // Reset values
  localparam logic [NDIR-1:0][7:0] DFUNC_RST =
    {8'h31, 8'h30, 8'h08, 8'h05, 8'h01, 8'h25, 8'h42, 8'h41, 8'h40, 8'h20};
  localparam logic [7:0]      DCOMP_RST = 8'h00;
  localparam logic [7:0]      VFUNC_RST = 8'h00;
  localparam logic [7:0]      VSRC_RST  = 8'h80;
  localparam logic [7:0]      DEAD_RST  = 8'h00;
  localparam logic [NDIR-1:0] DINV_RST  = 10'h000;
  localparam logic [NDIR-1:0] DSHOT_RST = 10'h000;
  localparam logic [3:0]      VINV_RST  = 4'h0;
  localparam logic [3:0]      VSHOT_RST = 4'h0;

endpackage : cic_pkg

// file: rtl/cic_chan_if.sv
// Control and result wires of one conditioning channel
`timescale 1ns/1ps
interface cic_chan_if;
  logic       raw;
  logic       inv;
  logic       shot;
  logic [7:0] dead;
  logic       cond;

  modport ctl
  (
    output raw,
    output inv,
    output shot,
    output dead,
    input  cond
  );

  modport chan
  (
    input  raw,
    input  inv,
    input  shot,
    input  dead,
    output cond
  );
endinterface : cic_chan_if

// file: rtl/cic_chan.sv
// One input channel: inversion, ON dead-time, one-shot shaping
`timescale 1ns/1ps
module cic_chan
  import cic_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYC,
  parameter int SHOT_LEN   = SHOT_CYC
)
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  cic_chan_if.chan ch_if
);

  typedef struct packed {
    logic [SUBW-1:0]  sub;
    logic [7:0]       ms;
    logic             qual;
    logic [SHOTW-1:0] shot;
    logic             out;
  } cic_chan_st_t;

  cic_chan_st_t s_r;
  cic_chan_st_t s_nxt;
  logic         on_w;

  always_comb
  begin
    s_nxt = s_r;
    on_w  = ch_if.raw ^ ch_if.inv;
    if (!on_w)
    begin
      // OFF is taken at once; only ON is delayed
      s_nxt.sub  = '0;
      s_nxt.ms   = '0;
      s_nxt.qual = 1'b0;
      s_nxt.shot = '0;
    end
    else if (!s_r.qual)
    begin
      if (s_r.ms >= ch_if.dead)
        s_nxt.qual = 1'b1;
      else if (s_r.sub == SUBW'(CYC_PER_MS - 1))
      begin
        s_nxt.sub = '0;
        s_nxt.ms  = s_r.ms + 8'h01;
      end
      else
        s_nxt.sub = s_r.sub + 1'b1;
    end
    else if (s_r.shot != SHOTW'(SHOT_LEN))
      s_nxt.shot = s_r.shot + 1'b1;
    // Pulse lasts SHOT_LEN cycles, then held off until input drops
    s_nxt.out = ch_if.shot
              ? (s_nxt.qual && (s_nxt.shot != SHOTW'(SHOT_LEN)))
              : s_nxt.qual;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ch_if.cond = s_r.out;

endmodule : cic_chan

// file: rtl/cic_top.sv
// Input conditioning and function routing for direct and soft inputs
`timescale 1ns/1ps
//
// How it works
// - Direct lines map to codes, reset 32,64,65,66,37,1,5,8,48,49.
// - Pulse variant: lines 0 to 3 feed only pulse outputs, set unused.
// - A per-line direct invert bit swaps ON and OFF sense, reset 0.
// - Direct ON is seen after a 0 to 250 ms dead-time, reset 0.
// - Direct one-shot bit drops a recognised ON after 250 us, reset off.
// - Each direct line may drive a composite code, reset 0 unused.
// - Four soft inputs each route to a function code, reset 0 unused.
// - Each soft input follows a selected internal signal, reset 128 off.
// - A per-input soft invert bit swaps ON and OFF sense, reset 0.
// - Soft inputs use their own 0 to 250 ms ON dead-time, reset 0.
// - Soft inputs have a one-shot enable bit, reset off.
module cic_top
  import cic_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYC,
  parameter int SHOT_LEN   = SHOT_CYC
)
(
  input  wire logic                mclk_in,
  input  wire logic                nrst_in,
  input  wire logic [NDIR-1:0]     direct_line_in,
  input  wire logic [127:0]        int_sig_in,
  input  wire logic                pulse_variant_in,
  input  wire logic [ADDRW-1:0]    addr_in,
  input  wire logic [DATAW-1:0]    wdata_in,
  input  wire logic                wr_in,
  input  wire logic                rd_in,
  output logic      [DATAW-1:0]    rdata_out,
  output logic      [255:0]        func_active_out,
  output logic      [NPLS-1:0]     pulse_lines_out
);

  localparam int NCH = NDIR + NVIRT;

  typedef struct packed {
    logic [NDIR-1:0][7:0]  dfunc;
    logic [NDIR-1:0][7:0]  dcomp;
    logic [NDIR-1:0]       dinv;
    logic [NDIR-1:0]       dshot;
    logic [7:0]            ddead;
    logic [NVIRT-1:0][7:0] vfunc;
    logic [NVIRT-1:0][7:0] vsrc;
    logic [NVIRT-1:0]      vinv;
    logic [NVIRT-1:0]      vshot;
    logic [7:0]            vdead;
    logic                  pulse_var;
    logic [NPLS-1:0]       pulse_lines;
    logic [255:0]          func;
    logic [DATAW-1:0]      rdata;
  } cic_top_st_t;

  cic_top_st_t       s_r;
  cic_top_st_t       s_nxt;
  logic [NCH-1:0]    raw_w;
  logic [NCH-1:0]    inv_w;
  logic [NCH-1:0]    shot_w;
  logic [NCH-1:0]    cond_w;
  logic [NVIRT-1:0]  vtrig_w;

  // Out-of-range dead-times saturate at the maximum
  function automatic logic [7:0] clamp_dead(input logic [7:0] v);
    clamp_dead = (v > DEAD_MAX) ? DEAD_MAX : v;
  endfunction : clamp_dead

  // Soft input triggers: codes up to and including 128 are not output signals
  always_comb
  begin
    for (int j = 0; j < NVIRT; j++)
    begin
      if (s_r.vsrc[j] > CODE_CONST_OFF)
        vtrig_w[j] = int_sig_in[s_r.vsrc[j][6:0]];
      else
        vtrig_w[j] = 1'b0;
    end
  end

  assign raw_w  = {vtrig_w, direct_line_in};
  assign inv_w  = {s_r.vinv, s_r.dinv};
  assign shot_w = {s_r.vshot, s_r.dshot};

  genvar k;
  generate
    for (k = 0; k < NCH; k++)
    begin : g_chan
      cic_chan_if ch_if ();
      assign ch_if.raw  = raw_w[k];
      assign ch_if.inv  = inv_w[k];
      assign ch_if.shot = shot_w[k];
      assign ch_if.dead = (k < NDIR) ? s_r.ddead : s_r.vdead;
      assign cond_w[k]  = ch_if.cond;

      cic_chan #(
        .CYC_PER_MS (CYC_PER_MS),
        .SHOT_LEN   (SHOT_LEN)
      ) u_chan (
        .mclk_in (mclk_in),
        .nrst_in (nrst_in),
        .ch_if   (ch_if.chan)
      );
    end
  endgenerate

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pulse_var = pulse_variant_in;

    // Pulse variant: lines 0..3 go only to the pulse decoder
    s_nxt.pulse_lines = s_r.pulse_var ? direct_line_in[NPLS-1:0]
                                      : '0;

    // Routing of conditioned inputs to function codes
    s_nxt.func = '0;
    for (int i = 0; i < NDIR; i++)
    begin
      if (cond_w[i] && !(s_r.pulse_var && (i < NPLS)))
      begin
        s_nxt.func[s_r.dfunc[i]] = 1'b1;
        s_nxt.func[s_r.dcomp[i]] = 1'b1;
      end
    end
    for (int j = 0; j < NVIRT; j++)
    begin
      if (cond_w[NDIR + j])
        s_nxt.func[s_r.vfunc[j]] = 1'b1;
    end
    // Code 0 means not used and never asserts
    s_nxt.func[CODE_NOT_USED] = 1'b0;

    // Register writes
    if (wr_in)
    begin
      for (int i = 0; i < NDIR; i++)
      begin
        if (addr_in == 8'(DFUNC_BASE + 4 * i))
          s_nxt.dfunc[i] = wdata_in[7:0];
        if (addr_in == 8'(DCOMP_BASE + 4 * i))
          s_nxt.dcomp[i] = wdata_in[7:0];
      end
      for (int j = 0; j < NVIRT; j++)
      begin
        if (addr_in == 8'(VFUNC_BASE + 4 * j))
          s_nxt.vfunc[j] = wdata_in[7:0];
        if (addr_in == 8'(VSRC_BASE + 4 * j))
          s_nxt.vsrc[j] = wdata_in[7:0];
      end
      case (addr_in)
        DINV_OFF:  s_nxt.dinv  = wdata_in[NDIR-1:0];
        DDEAD_OFF: s_nxt.ddead = clamp_dead(wdata_in[7:0]);
        DSHOT_OFF: s_nxt.dshot = wdata_in[NDIR-1:0];
        VINV_OFF:  s_nxt.vinv  = wdata_in[NVIRT-1:0];
        VDEAD_OFF: s_nxt.vdead = clamp_dead(wdata_in[7:0]);
        VSHOT_OFF: s_nxt.vshot = wdata_in[NVIRT-1:0];
        default:   ;
      endcase
    end

    // Register reads: data stand for one cycle, zero otherwise
    s_nxt.rdata = '0;
    if (rd_in)
    begin
      for (int i = 0; i < NDIR; i++)
      begin
        if (addr_in == 8'(DFUNC_BASE + 4 * i))
          s_nxt.rdata[7:0] = s_r.dfunc[i];
        if (addr_in == 8'(DCOMP_BASE + 4 * i))
          s_nxt.rdata[7:0] = s_r.dcomp[i];
      end
      for (int j = 0; j < NVIRT; j++)
      begin
        if (addr_in == 8'(VFUNC_BASE + 4 * j))
          s_nxt.rdata[7:0] = s_r.vfunc[j];
        if (addr_in == 8'(VSRC_BASE + 4 * j))
          s_nxt.rdata[7:0] = s_r.vsrc[j];
      end
      case (addr_in)
        DINV_OFF:  s_nxt.rdata[NDIR-1:0]  = s_r.dinv;
        DDEAD_OFF: s_nxt.rdata[7:0]       = s_r.ddead;
        DSHOT_OFF: s_nxt.rdata[NDIR-1:0]  = s_r.dshot;
        VINV_OFF:  s_nxt.rdata[NVIRT-1:0] = s_r.vinv;
        VDEAD_OFF: s_nxt.rdata[7:0]       = s_r.vdead;
        VSHOT_OFF: s_nxt.rdata[NVIRT-1:0] = s_r.vshot;
        STAT_OFF:
        begin
          s_nxt.rdata[STAT_DIR_LSB +: NDIR]   = cond_w[NDIR-1:0];
          s_nxt.rdata[STAT_VIRT_LSB +: NVIRT] = cond_w[NCH-1:NDIR];
          s_nxt.rdata[STAT_PLS_BIT]           = s_r.pulse_var;
        end
        default:   ;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      s_r             <= '0;
      s_r.dfunc       <= DFUNC_RST;
      s_r.dcomp       <= {NDIR{DCOMP_RST}};
      s_r.dinv        <= DINV_RST;
      s_r.dshot       <= DSHOT_RST;
      s_r.ddead       <= DEAD_RST;
      s_r.vfunc       <= {NVIRT{VFUNC_RST}};
      s_r.vsrc        <= {NVIRT{VSRC_RST}};
      s_r.vinv        <= VINV_RST;
      s_r.vshot       <= VSHOT_RST;
      s_r.vdead       <= DEAD_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata_out       = s_r.rdata;
  assign func_active_out = s_r.func;
  assign pulse_lines_out = s_r.pulse_lines;

endmodule : cic_top

// file: testbench/cic_ctrl_model.sv
// Far-side controller model driving the direct input lines
`timescale 1ns/1ps
module cic_ctrl_model
(
  input  wire logic       mclk_in,
  input  wire logic [9:0] want_in,
  output logic      [9:0] direct_line_out
);
  // Changes only just after an edge, so levels hold a full cycle
  always_ff @(posedge mclk_in)
    direct_line_out <= want_in;
endmodule : cic_ctrl_model

// file: testbench/cic_top_properties.sv
// Port-level properties of the input conditioning block
`timescale 1ns/1ps
module cic_top_properties
  import cic_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYC,
  parameter int SHOT_LEN   = SHOT_CYC
)
(
  input wire logic             mclk_in,
  input wire logic             nrst_in,
  input wire logic             pulse_variant_in,
  input wire logic [ADDRW-1:0] addr_in,
  input wire logic [DATAW-1:0] wdata_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [DATAW-1:0] rdata_out,
  input wire logic [255:0]     func_active_out,
  input wire logic [NPLS-1:0]  pulse_lines_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  // Bits above each mask field must read zero
  localparam logic [31:0] DMASK = 32'hffff_fc00;
  localparam logic [31:0] VMASK = 32'hffff_fff0;

  // Write, one idle cycle, then read of the same place
  sequence wr_rd(a);
    wr_in && addr_in == a ##2 rd_in && addr_in == a;
  endsequence

  property code_rb(a);
    wr_rd(a) |=> rdata_out == {24'h0, $past(wdata_in[7:0], 3)};
  endproperty

  // Out-of-range dead-times must read back clipped
  property dead_rb(a);
    wr_rd(a) |=> rdata_out == (($past(wdata_in[7:0], 3) > 8'd250) ?
      32'd250 : {24'h0, $past(wdata_in[7:0], 3)});
  endproperty

  // Variant input low for three samples flushes both flops, pulse_var then pulse_lines
  sequence var_off;
    !pulse_variant_in [*3];
  endsequence

  property upper_zero(a, m);
    rd_in && addr_in == a |=> (rdata_out & m) == 32'h0;
  endproperty

  func_rb_a: assert property (code_rb(DFUNC_BASE))
    else $error("line function readback wrong");
  vsrc_rb_a: assert property (code_rb(VSRC_BASE))
    else $error("soft source readback wrong");
  dead_sat_a: assert property (dead_rb(DDEAD_OFF))
    else $error("direct dead-time readback wrong");
  vdead_sat_a: assert property (dead_rb(VDEAD_OFF))
    else $error("soft dead-time readback wrong");
  dinv_width_a: assert property (upper_zero(DINV_OFF, DMASK))
    else $error("direct invert mask too wide");
  dshot_width_a: assert property (upper_zero(DSHOT_OFF, DMASK))
    else $error("direct one-shot mask too wide");
  vinv_width_a: assert property (upper_zero(VINV_OFF, VMASK))
    else $error("soft invert mask too wide");
  vshot_width_a: assert property (upper_zero(VSHOT_OFF, VMASK))
    else $error("soft one-shot mask too wide");
  pulse_gate_a: assert property (var_off |-> pulse_lines_out == 4'h0)
    else $error("pulse lines active outside pulse variant");
  code_zero_a: assert property (func_active_out[0] == 1'b0)
    else $error("unused code asserted");
endmodule : cic_top_properties

bind cic_top cic_top_properties #(.CYC_PER_MS(CYC_PER_MS),
  .SHOT_LEN(SHOT_LEN)) CHK (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .pulse_variant_in(pulse_variant_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .func_active_out(func_active_out),
  .pulse_lines_out(pulse_lines_out));

// file: testbench/tb_input_signal_conditioning.sv
// Self-checking bench for the input conditioning block
`timescale 1ns/1ps
module tb_input_signal_conditioning;
  import cic_pkg::*;
  localparam int CPM = 10;
  localparam int SL  = 8;
  logic         mclk_in = 1'b0;
  logic         nrst_in = 1'b0;
  logic [9:0]   want    = 10'h0;
  logic [9:0]   lines;
  logic [127:0] int_sig = '0;
  logic         pvar    = 1'b0;
  logic [7:0]   addr    = 8'h0;
  logic [31:0]  wdata   = '0;
  logic         wr      = 1'b0;
  logic         rd      = 1'b0;
  logic [31:0]  rdata;
  logic [255:0] func;
  logic [3:0]   plines;
  int           errors       = 0;
  int           total_checks = 0;
  int           first;
  int           cnt;
  logic [7:0]   dflt [10] = '{8'h20, 8'h40, 8'h41, 8'h42, 8'h25,
                              8'h01, 8'h05, 8'h08, 8'h30, 8'h31};
  logic [7:0]   moff [4]  = '{DINV_OFF, DSHOT_OFF, VINV_OFF, VSHOT_OFF};
  logic [31:0]  mval [4]  = '{32'h3ff, 32'h3ff, 32'hf, 32'hf};

  always #20 mclk_in = ~mclk_in;

  cic_ctrl_model FAR (.mclk_in(mclk_in), .want_in(want),
    .direct_line_out(lines));
  cic_top #(.CYC_PER_MS(CPM), .SHOT_LEN(SL)) DUT (.mclk_in(mclk_in),
    .nrst_in(nrst_in), .direct_line_in(lines), .int_sig_in(int_sig),
    .pulse_variant_in(pvar), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .func_active_out(func), .pulse_lines_out(plines));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rc

  // First cycle a function bit is high, and how many cycles
  task automatic watch(input int code, input int n);
    first = -1;
    cnt = 0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk_in);
      #1;
      if (func[code] === 1'b1)
      begin
        if (first < 0)
          first = i;
        cnt++;
      end
    end
  endtask : watch

  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (100000) @(posedge mclk_in);
    errors++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      rc(DFUNC_BASE + 8'(4 * i), {24'h0, dflt[i]});
      rc(DCOMP_BASE + 8'(4 * i), 32'h0);
    end
    for (int j = 0; j < 4; j++)
    begin
      rc(VFUNC_BASE + 8'(4 * j), 32'h0);
      rc(VSRC_BASE + 8'(4 * j), 32'h80);
    end
    rc(DDEAD_OFF, 32'h0);
    rc(VDEAD_OFF, 32'h0);
    foreach (moff[k])
    begin
      rc(moff[k], 32'h0);
      wr_reg(moff[k], 32'hffff_ffff);
      rc(moff[k], mval[k]);
      wr_reg(moff[k], 32'h0);
    end
    wr_reg(8'hfc, 32'hffff_ffff);
    rc(8'hfc, 32'h0);
    wr_reg(DFUNC_BASE, 32'h120);
    rc(DFUNC_BASE, 32'h20);
    wr_reg(VSRC_BASE, 32'h82);
    rc(VSRC_BASE, 32'h82);
    wr_reg(DDEAD_OFF, 32'd255);
    rc(DDEAD_OFF, 32'd250);
    wr_reg(VDEAD_OFF, 32'd255);
    rc(VDEAD_OFF, 32'd250);
    wr_reg(DDEAD_OFF, 32'h0);
    wr_reg(DCOMP_BASE + 8'd20, 32'h9);
    @(posedge mclk_in);
    want <= 10'h020;
    watch(1, 4);
    check(32'(first), 32'd2);
    check({31'h0, func[9]}, 32'h1);
    @(posedge mclk_in);
    want <= 10'h000;
    watch(1, 4);
    check(32'(cnt), 32'd2);
    wr_reg(DINV_OFF, 32'h40);
    repeat (4) @(posedge mclk_in);
    want <= 10'h040;
    watch(5, 4);
    check(32'(cnt), 32'd2);
    wr_reg(DINV_OFF, 32'h0);
    want <= 10'h000;
    wr_reg(DDEAD_OFF, 32'd2);
    want <= 10'h080;
    watch(8, 12);
    want <= 10'h000;
    check(32'(cnt), 32'd0);
    watch(8, 30);
    check(32'(cnt), 32'd0);
    want <= 10'h080;
    watch(8, 30);
    check(32'(first), 32'(2 * CPM + 2));
    want <= 10'h000;
    wr_reg(DDEAD_OFF, 32'h0);
    wr_reg(DSHOT_OFF, 32'h100);
    want <= 10'h100;
    watch(48, 30);
    check(32'(first), 32'd2);
    check(32'(cnt), 32'(SL));
    want <= 10'h000;
    wr_reg(VFUNC_BASE, 32'h64);
    wr_reg(VDEAD_OFF, 32'd1);
    wr_reg(VSHOT_OFF, 32'h1);
    int_sig <= 128'h4;
    watch(100, 40);
    check(32'(first), 32'(CPM + 1));
    check(32'(cnt), 32'(SL));
    int_sig <= '0;
    wr_reg(VDEAD_OFF, 32'h0);
    wr_reg(VFUNC_BASE + 8'd4, 32'h65);
    watch(101, 4);
    check(32'(cnt), 32'd0);
    wr_reg(VINV_OFF, 32'h2);
    watch(101, 4);
    check({31'h0, func[101]}, 32'h1);
    pvar <= 1'b1;
    want <= 10'h001;
    watch(32, 5);
    check(32'(cnt), 32'd0);
    check({28'h0, plines}, 32'h1);
    rc(STAT_OFF, 32'h0001_0801);
    @(posedge mclk_in);
    #1;
    check(rdata, 32'h0);
    // Line 0 stays high so the gate is really exercised
    pvar <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
    check({28'h0, plines}, 32'h0);
    check({31'h0, func[32]}, 32'h1);
    summarize();
  end
endmodule : tb_input_signal_conditioning
